// >>> ssfp_frame.sv
`timescale 1ns/100ps
// Notes on behaviour
// - start on enable with data, or write while enabled
// - transmit interrupt when FIFO holds four or fewer
// - master clock between fsys/65024 and fsys/2
// - word 4 to 16 bits, MSB first
// - idle clock low/inactive; SPI clock toggles only during data, pulse format adds one clock before and one after
// - SPI select active low across the frame
// - pulse select one bit; out rising, in falling
// - pulse idle: clock, select low, data hi-Z
// - write gives one-clock select pulse, then data
// - pulse format: push word on rising after LSB
// - polarity sets SPI clock idle level
// - phase selects first or second capture edge
// - polarity 0 idle: clock low, select high, data low
// - phase 0: select, half later data, then clock
// - select rises one clock after last capture; with phase 0 it rises 1.5 clocks after, one after the last trailing edge
// - phase 0 continuous: select pulses between words
// - continuous end: select idle one clock after
// - disabled: data output hi-Z, input stays input
// - clock from even prescale then rate plus one
// - transmit interrupt also while disabled
module ssfp_frame (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic CE,
	input ssfp_pkg::ssfp_cfg_t CFG,
	input wire logic TX_VALID,
	input wire logic [ssfp_pkg::WORD_W-1:0] TX_DATA,
	input wire logic [ssfp_pkg::LEVEL_W-1:0] TX_LEVEL,
	input wire logic SERIAL_CLOCK_PIN_IN,
	input wire logic FRAME_SELECT_PIN_IN,
	input wire logic SERIAL_IN_PIN,
	output ssfp_pkg::ssfp_pin_t SERIAL_CLOCK_PIN_OUT,
	output ssfp_pkg::ssfp_pin_t FRAME_SELECT_PIN_OUT,
	output ssfp_pkg::ssfp_pin_t SERIAL_OUT_PIN,
	output logic TX_POP,
	output logic RX_VALID,
	output logic [ssfp_pkg::WORD_W-1:0] RX_DATA,
	output logic TX_IRQ,
	output logic BUSY
);

	ssfp_pkg::ssfp_state_t state;
	logic half;
	logic [6:0] pre_cnt;
	logic [7:0] rate_cnt;
	logic sck_s1, sck_s2, sck_q;
	logic fss_s1, fss_s2, fss_q;
	logic din_s1, din_s2;
	logic [ssfp_pkg::WORD_W-1:0] tx_sh, rx_sh;
	logic [3:0] bit_idx;
	logic busy_word, rx_pend, s_present;
	logic sclk, fss, dout, dout_oe;

	logic frame_pulse_format, shift_on_lead, idle_clk, idle_fss, tick;
	logic [3:0] size_m1;
	logic [6:0] pre_top;
	logic m_load, m_present, m_lead, m_trail, m_launch;
	logic s_change, s_lead, s_trail, s_sel, s_load;
	logic load_ev, present_ev, lead_ev, trail_ev, word_done;
	logic more, next_dout_oe;

	assign frame_pulse_format = (CFG.fmt == ssfp_pkg::SSFP_FMT_PULSE);
	assign shift_on_lead = frame_pulse_format | CFG.cpha;
	assign idle_clk = frame_pulse_format ? 1'b0 : CFG.cpol;
	assign idle_fss = !frame_pulse_format;
	assign size_m1 = (CFG.size_m1 < ssfp_pkg::MIN_SIZE_M1) ? ssfp_pkg::MIN_SIZE_M1 : CFG.size_m1;
	assign more = CFG.enable && TX_VALID;

	// half-period tick: prescale/2 then rate+1; odd prescale bit ignored
	assign pre_top = (CFG.prescale[7:1] == 7'h00) ? 7'h00 : CFG.prescale[7:1] - 7'h01;
	assign tick = (pre_cnt == pre_top) && (rate_cnt == CFG.rate);

	// pin inputs pass two flops; the third stage only feeds edge detection
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_q <= 1'b0;
			fss_s1 <= 1'b1;
			fss_s2 <= 1'b1;
			fss_q <= 1'b1;
			din_s1 <= 1'b0;
			din_s2 <= 1'b0;
		end else if (CE) begin
			sck_s1 <= SERIAL_CLOCK_PIN_IN;
			sck_s2 <= sck_s1;
			sck_q <= sck_s2;
			fss_s1 <= FRAME_SELECT_PIN_IN;
			fss_s2 <= fss_s1;
			fss_q <= fss_s2;
			din_s1 <= SERIAL_IN_PIN;
			din_s2 <= din_s1;
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			pre_cnt <= ssfp_pkg::PRE_CNT_RST;
			rate_cnt <= ssfp_pkg::RATE_CNT_RST;
		end else if (CE) begin
			if (state == ssfp_pkg::SSFP_IDLE || tick) begin
				pre_cnt <= ssfp_pkg::PRE_CNT_RST;
				rate_cnt <= ssfp_pkg::RATE_CNT_RST;
			end else if (pre_cnt == pre_top) begin
				pre_cnt <= ssfp_pkg::PRE_CNT_RST;
				rate_cnt <= rate_cnt + 8'h01;
			end else begin
				pre_cnt <= pre_cnt + 7'h01;
			end
		end
	end

	// slave events from the synchronised pins
	assign s_change = sck_s2 ^ sck_q;
	assign s_lead = s_change && (sck_s2 != idle_clk);
	assign s_trail = s_change && (sck_s2 == idle_clk);
	assign s_sel = !fss_s2;
	assign word_done = trail_ev && busy_word && (bit_idx == 4'h0);
	always_comb begin
		s_load = 1'b0;
		if (frame_pulse_format) begin
			s_load = s_trail && fss_s2;
		end else if (fss_q && !fss_s2) begin
			s_load = 1'b1;
		end else if (word_done && s_sel) begin
			s_load = 1'b1;
		end
	end

	// master events decoded from the frame state
	assign m_launch = (state == ssfp_pkg::SSFP_IDLE) && more;
	assign m_load = m_launch || ((state == ssfp_pkg::SSFP_POST) && tick && half && more && !frame_pulse_format && CFG.cpha);
	assign m_present = (state == ssfp_pkg::SSFP_PRE) && tick && !half && !shift_on_lead;
	assign m_lead = tick && (((state == ssfp_pkg::SSFP_PRE) && half)
		|| ((state == ssfp_pkg::SSFP_BITS) && (sclk == idle_clk))
		|| ((state == ssfp_pkg::SSFP_POST) && !half && frame_pulse_format));
	assign m_trail = tick && (state == ssfp_pkg::SSFP_BITS) && (sclk != idle_clk);

	assign load_ev = CFG.enable && (CFG.master ? m_load : s_load);
	assign present_ev = CFG.master ? m_present : s_present;
	assign lead_ev = CFG.enable && (CFG.master ? m_lead : (s_lead && (frame_pulse_format || s_sel)));
	assign trail_ev = CFG.enable && (CFG.master ? m_trail : (s_trail && (frame_pulse_format || s_sel)));

	// shift datapath shared by master and slave
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			tx_sh <= ssfp_pkg::WORD_RST;
			rx_sh <= ssfp_pkg::WORD_RST;
			bit_idx <= ssfp_pkg::BIT_IDX_RST;
			busy_word <= 1'b0;
			rx_pend <= 1'b0;
			s_present <= 1'b0;
			dout <= 1'b0;
			TX_POP <= 1'b0;
			RX_VALID <= 1'b0;
			RX_DATA <= ssfp_pkg::WORD_RST;
		end else if (CE) begin
			TX_POP <= load_ev && TX_VALID;
			RX_VALID <= 1'b0;
			s_present <= !CFG.master && s_load && !shift_on_lead;
			if (!CFG.enable) begin
				busy_word <= 1'b0;
				rx_pend <= 1'b0;
				dout <= 1'b0;
			end else begin
				if (word_done) begin
					busy_word <= 1'b0;
					if (frame_pulse_format) begin
						rx_pend <= 1'b1;
					end else begin
						RX_VALID <= 1'b1;
						// with phase 1 the last capture lands on this same trailing edge
						RX_DATA <= shift_on_lead ? {rx_sh[ssfp_pkg::WORD_W-2:0], din_s2} : rx_sh;
					end
				end
				if (lead_ev && rx_pend) begin
					rx_pend <= 1'b0;
					RX_VALID <= 1'b1;
					RX_DATA <= rx_sh;
				end
				if (load_ev) begin
					// an empty FIFO in slave mode sends zeros
					tx_sh <= TX_VALID ? TX_DATA : ssfp_pkg::WORD_RST;
					rx_sh <= ssfp_pkg::WORD_RST;
					bit_idx <= size_m1;
					busy_word <= 1'b1;
				end else if (present_ev) begin
					dout <= tx_sh[bit_idx];
				end else if (lead_ev && busy_word) begin
					if (shift_on_lead) begin
						dout <= tx_sh[bit_idx];
					end else begin
						rx_sh <= {rx_sh[ssfp_pkg::WORD_W-2:0], din_s2};
					end
				end else if (trail_ev && busy_word) begin
					if (shift_on_lead) begin
						rx_sh <= {rx_sh[ssfp_pkg::WORD_W-2:0], din_s2};
					end else if (bit_idx != 4'h0) begin
						dout <= tx_sh[bit_idx - 4'h1];
					end
					if (bit_idx != 4'h0) begin
						bit_idx <= bit_idx - 4'h1;
					end
				end
				if (state == ssfp_pkg::SSFP_GAP && CFG.master && !frame_pulse_format) begin
					dout <= 1'b0;
				end
			end
		end
	end

	// master frame sequencer
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			state <= ssfp_pkg::SSFP_IDLE;
			half <= 1'b0;
			sclk <= 1'b0;
			fss <= 1'b1;
		end else if (CE) begin
			if (!CFG.enable || !CFG.master) begin
				state <= ssfp_pkg::SSFP_IDLE;
				half <= 1'b0;
				sclk <= idle_clk;
				fss <= idle_fss;
			end else begin
				case (state)
				ssfp_pkg::SSFP_IDLE: begin
					sclk <= idle_clk;
					fss <= idle_fss;
					half <= 1'b0;
					if (m_launch) begin
						state <= ssfp_pkg::SSFP_PRE;
						fss <= frame_pulse_format;
						sclk <= frame_pulse_format ? 1'b1 : idle_clk;
					end
				end
				ssfp_pkg::SSFP_PRE: begin
					if (tick) begin
						half <= !half;
						if (!half) begin
							sclk <= idle_clk;
						end else begin
							state <= ssfp_pkg::SSFP_BITS;
							sclk <= !idle_clk;
							fss <= 1'b0;
						end
					end
				end
				ssfp_pkg::SSFP_BITS: begin
					if (tick) begin
						sclk <= !sclk;
						if (m_trail && bit_idx == 4'h0) begin
							state <= ssfp_pkg::SSFP_POST;
							half <= 1'b0;
						end
					end
				end
				ssfp_pkg::SSFP_POST: begin
					if (tick) begin
						half <= !half;
						sclk <= (frame_pulse_format && !half) ? 1'b1 : idle_clk;
						if (half) begin
							if (more && !frame_pulse_format && CFG.cpha) begin
								state <= ssfp_pkg::SSFP_PRE;
							end else begin
								state <= ssfp_pkg::SSFP_GAP;
								fss <= idle_fss;
							end
						end
					end
				end
				ssfp_pkg::SSFP_GAP: begin
					if (tick) begin
						half <= !half;
						if (half || frame_pulse_format) begin
							state <= ssfp_pkg::SSFP_IDLE;
						end
					end
				end
				default: begin
					state <= ssfp_pkg::SSFP_IDLE;
				end
				endcase
			end
		end
	end

	always_comb begin
		next_dout_oe = 1'b0;
		if (!CFG.enable) begin
			next_dout_oe = 1'b0;
		end else if (CFG.master) begin
			if (!frame_pulse_format) begin
				next_dout_oe = 1'b1;
			end else begin
				next_dout_oe = (state == ssfp_pkg::SSFP_PRE) || (state == ssfp_pkg::SSFP_BITS)
					|| (state == ssfp_pkg::SSFP_POST);
			end
		end else begin
			next_dout_oe = frame_pulse_format ? (busy_word || rx_pend) : s_sel;
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			dout_oe <= 1'b0;
			SERIAL_CLOCK_PIN_OUT <= '0;
			FRAME_SELECT_PIN_OUT <= '0;
			SERIAL_OUT_PIN <= '0;
			TX_IRQ <= 1'b1;
			BUSY <= 1'b0;
		end else if (CE) begin
			dout_oe <= next_dout_oe;
			SERIAL_CLOCK_PIN_OUT.o <= sclk;
			SERIAL_CLOCK_PIN_OUT.oe <= CFG.enable && CFG.master;
			FRAME_SELECT_PIN_OUT.o <= fss;
			FRAME_SELECT_PIN_OUT.oe <= CFG.enable && CFG.master;
			SERIAL_OUT_PIN.o <= dout;
			SERIAL_OUT_PIN.oe <= dout_oe;
			TX_IRQ <= !CFG.enable || (TX_LEVEL <= ssfp_pkg::TX_IRQ_LEVEL);
			BUSY <= busy_word || (state != ssfp_pkg::SSFP_IDLE);
		end
	end

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!NRST || !CE);

	a_start_launch: assert property (CFG.master && m_launch |=> state == ssfp_pkg::SSFP_PRE)
		else $error("frame did not start with data present");
	a_irq_level: assert property ($past(CE) |-> TX_IRQ == $past(!CFG.enable || TX_LEVEL <= ssfp_pkg::TX_IRQ_LEVEL))
		else $error("transmit interrupt level wrong");
	a_msb_present: assert property (m_present && CFG.enable |=> dout == $past(tx_sh[bit_idx]))
		else $error("first bit not presented");
	a_idle_clock: assert property (CFG.master && $stable(CFG) && state == ssfp_pkg::SSFP_IDLE
		&& $past(state) == ssfp_pkg::SSFP_IDLE |-> sclk == idle_clk)
		else $error("clock not at idle level");
	a_spi_select: assert property (CFG.master && !frame_pulse_format && state == ssfp_pkg::SSFP_BITS |-> !fss)
		else $error("select high during frame");
	a_pulse_select: assert property (CFG.master && frame_pulse_format && state == ssfp_pkg::SSFP_PRE
		|-> fss ##1 (state != ssfp_pkg::SSFP_BITS || !fss))
		else $error("frame pulse missing");
	a_pulse_idle: assert property (CFG.master && frame_pulse_format && $stable(CFG) && state == ssfp_pkg::SSFP_IDLE
		&& $past(state) == ssfp_pkg::SSFP_IDLE |-> !dout_oe && !fss)
		else $error("pulse format idle drives pins");
	a_disable_hiz: assert property (!CFG.enable ##1 !CFG.enable |=> !SERIAL_OUT_PIN.oe)
		else $error("data output driven while disabled");
	a_tail_select: assert property (CFG.master && !frame_pulse_format && state == ssfp_pkg::SSFP_POST |-> !fss)
		else $error("select released before tail clock");
	a_gap_pulse: assert property (CFG.master && !frame_pulse_format && !CFG.cpha && state == ssfp_pkg::SSFP_GAP |-> fss)
		else $error("no select pulse between words");

	c_pulse_frame: cover property (CFG.master && frame_pulse_format && state == ssfp_pkg::SSFP_POST ##[1:300] RX_VALID);
	c_spi_gap: cover property (CFG.master && !CFG.cpha && state == ssfp_pkg::SSFP_GAP ##[1:300] state == ssfp_pkg::SSFP_PRE);
	c_spi_chain: cover property (CFG.master && CFG.cpha && state == ssfp_pkg::SSFP_POST ##1 state == ssfp_pkg::SSFP_PRE);
	c_slave_word: cover property (!CFG.master && RX_VALID);

endmodule

// >>> ssfp_frame_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module ssfp_frame_tb;
	logic MCLK = 0;
	logic NRST = 0;
	ssfp_pkg::ssfp_cfg_t cfg = '0;
	logic tx_valid = 0;
	logic [15:0] tx_data = 16'h0000;
	logic [3:0] tx_level = 4'h0;
	logic [15:0] pload = 16'h0000;
	logic [4:0] bits = 5'h08;
	ssfp_pkg::ssfp_pin_t sck, fss, sdo;
	logic miso, tx_pop, rx_valid, tx_irq, busy, sck_q, fss_q;
	logic [15:0] rx_data, pgot;
	logic [15:0] txq[$];
	logic [15:0] rxq[$];
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int edges = 0;
	int rises = 0;
	int fss_hi = 0;
	logic ext_sck = 1'b0;
	logic ext_fss = 1'b1;
	logic ext_din = 1'b0;
	always #5 MCLK = ~MCLK;
	// slave scenarios drive the link from the bench; master ones loop the pins back
	ssfp_frame uut (.MCLK(MCLK), .NRST(NRST), .CE(1'b1), .CFG(cfg), .TX_VALID(tx_valid), .TX_DATA(tx_data),
		.TX_LEVEL(tx_level), .SERIAL_CLOCK_PIN_IN(cfg.master ? sck.o : ext_sck),
		.FRAME_SELECT_PIN_IN(cfg.master ? fss.o : ext_fss), .SERIAL_IN_PIN(cfg.master ? miso : ext_din),
		.SERIAL_CLOCK_PIN_OUT(sck), .FRAME_SELECT_PIN_OUT(fss), .SERIAL_OUT_PIN(sdo), .TX_POP(tx_pop),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .TX_IRQ(tx_irq), .BUSY(busy));
	ssfp_peer peer (.sck(sck.o), .fss(fss.o), .mosi(sdo.o), .cfg(cfg), .load(pload), .bits(bits), .miso(miso),
		.got(pgot));
	// fifo model: pop on the sampled pulse, then present the new head
	always @(posedge MCLK) begin
		cycles++;
		if (rx_valid) rxq.push_back(rx_data);
		if (sck.o !== sck_q) edges++;
		if (fss.o === 1'b1 && fss_q === 1'b0) rises++;
		if (fss.o === 1'b1) fss_hi++;
		sck_q = sck.o;
		fss_q = fss.o;
		if (tx_pop === 1'b1 && txq.size() != 0) txq.pop_front();
		if (cycles == 40000) begin
			num_errors++;
			complete_run();
		end
		#1;
		tx_valid = (txq.size() != 0);
		tx_data = tx_valid ? txq[0] : 16'h0000;
		tx_level = 4'(txq.size());
	end
	task automatic step(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic set_cfg(input ssfp_pkg::ssfp_fmt_t f, input logic pol, input logic pha, input logic [3:0] sm1);
		cfg = '0;
		cfg.master = 1'b1;
		cfg.fmt = f;
		cfg.cpol = pol;
		cfg.cpha = pha;
		cfg.size_m1 = sm1;
		cfg.prescale = 8'h02;
		// half period of four cycles: the looped data reaches the synchronised input three cycles after the internal clock edge
		cfg.rate = 8'h03;
		bits = 5'(sm1) + 5'h01;
		rxq.delete();
		step(3);
		edges = 0;
		rises = 0;
		fss_hi = 0;
	endtask
	task automatic wait_done();
		int k;
		k = 0;
		while ((busy !== 1'b0 || txq.size() != 0 || k < 8) && k < 3000) begin
			step(1);
			k++;
		end
		`CHK(k < 3000, 1'b1)
		step(12);
	endtask
	task automatic one_word(input ssfp_pkg::ssfp_fmt_t f, input logic pol, input logic pha, input logic [3:0] sm1,
		input logic [15:0] w, input logic [15:0] pw);
		logic [15:0] m;
		m = 16'hFFFF >> (4'hF - sm1);
		set_cfg(f, pol, pha, sm1);
		pload = pw << (4'hF - sm1);
		cfg.enable = 1'b1;
		step(2);
		`CHK(sck.o, f ? 1'b0 : pol)
		`CHK(fss.o, f ? 1'b0 : 1'b1)
		if (f) `CHK(sdo.oe, 1'b0)
		txq.push_back(w);
		wait_done();
		`CHK(rxq.size(), 1)
		`CHK(rxq[0], pw & m)
		`CHK(pgot & m, w & m)
		`CHK(edges, f ? 2 * bits + 4 : 2 * bits)
		`CHK(fss.o, f ? 1'b0 : 1'b1)
		if (f) `CHK(fss_hi, 8)
		cfg.enable = 1'b0;
		$display("word fmt %0d pol %0d pha %0d bits %0d done", f, pol, pha, bits);
	endtask
	task automatic stream(input logic pha);
		set_cfg(ssfp_pkg::SSFP_FMT_SPI, 1'b0, pha, 4'h7);
		repeat (5) txq.push_back(16'h00C3);
		step(2);
		`CHK(tx_irq, 1'b1)
		cfg.enable = 1'b1;
		step(1);
		`CHK(tx_irq, 1'b0)
		wait_done();
		`CHK(tx_irq, 1'b1)
		`CHK(rxq.size(), 5)
		`CHK(rises, pha ? 1 : 5)
		cfg.enable = 1'b0;
		$display("stream pha %0d done", pha);
	endtask
	task automatic slave_word(input logic [7:0] w, input logic [7:0] pw);
		logic [7:0] got;
		got = 8'h00;
		set_cfg(ssfp_pkg::SSFP_FMT_SPI, 1'b0, 1'b0, 4'h7);
		cfg.master = 1'b0;
		txq.push_back(16'(w));
		step(2);
		cfg.enable = 1'b1;
		step(2);
		ext_fss = 1'b0;
		step(6);
		for (int i = 7; i >= 0; i--) begin
			got[i] = sdo.o;
			ext_din = pw[i];
			ext_sck = 1'b1;
			step(6);
			ext_sck = 1'b0;
			step(6);
		end
		ext_fss = 1'b1;
		step(6);
		`CHK(got, w)
		`CHK(rxq.size(), 1)
		`CHK(rxq[0], 16'(pw))
		`CHK(txq.size(), 0)
		cfg.enable = 1'b0;
		$display("slave word done");
	endtask
	task automatic abort_mid();
		set_cfg(ssfp_pkg::SSFP_FMT_SPI, 1'b1, 1'b0, 4'hF);
		cfg.enable = 1'b1;
		txq.push_back(16'h1234);
		step(20);
		`CHK(busy, 1'b1)
		cfg.enable = 1'b0;
		step(3);
		`CHK(sdo.oe, 1'b0)
		`CHK(sck.o, 1'b1)
		`CHK(busy, 1'b0)
		`CHK(tx_irq, 1'b1)
		txq.delete();
		$display("abort done");
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		step(3);
		`CHK(tx_irq, 1'b1)
		`CHK(sdo.oe, 1'b0)
		NRST = 1'b1;
		for (int i = 0; i < 4; i++) one_word(ssfp_pkg::SSFP_FMT_SPI, i[1], i[0], 4'h7, 16'h00A5 ^ 16'(i), 16'h005C);
		one_word(ssfp_pkg::SSFP_FMT_SPI, 1'b0, 1'b0, 4'h3, 16'h0009, 16'h0006);
		one_word(ssfp_pkg::SSFP_FMT_SPI, 1'b1, 1'b1, 4'hF, 16'hB1E2, 16'h4D39);
		one_word(ssfp_pkg::SSFP_FMT_PULSE, 1'b0, 1'b0, 4'h3, 16'h000A, 16'h0005);
		one_word(ssfp_pkg::SSFP_FMT_PULSE, 1'b0, 1'b0, 4'hF, 16'hC3A6, 16'h5A1F);
		stream(1'b0);
		stream(1'b1);
		slave_word(8'h96, 8'h3C);
		abort_mid();
		complete_run();
	end
endmodule

// >>> ssfp_peer.sv
`timescale 1ns/100ps
module ssfp_peer (
	input wire logic sck,
	input wire logic fss,
	input wire logic mosi,
	input ssfp_pkg::ssfp_cfg_t cfg,
	input wire logic [15:0] load,
	input wire logic [4:0] bits,
	output logic miso,
	output logic [15:0] got
);
	logic [15:0] sh = 16'h0000;
	int cnt = 0;
	wire spi = (cfg.fmt == ssfp_pkg::SSFP_FMT_SPI);
	initial miso = 1'b0;
	initial got = 16'h0000;
	always @(negedge fss) if (spi) begin
		sh = load;
		cnt = 0;
		got = 16'h0000;
		if (!cfg.cpha) begin
			miso = sh[15];
			sh = sh << 1;
		end
	end
	// released line shows the inverse, so stale data never passes for a match
	always @(posedge fss) if (spi) miso = ~miso;
	always @(sck) if (spi && !fss) begin
		if ((sck != cfg.cpol) ^ cfg.cpha) begin
			if (cnt < bits) got = {got[14:0], mosi};
			cnt++;
		end else begin
			miso = sh[15];
			sh = sh << 1;
		end
	end
	always @(negedge sck) if (!spi) begin
		if (fss) begin
			sh = load;
			cnt = 0;
			got = 16'h0000;
		end else if (cnt < bits) begin
			got = {got[14:0], mosi};
			cnt++;
		end
	end
	always @(posedge sck) if (!spi) begin
		miso = sh[15];
		sh = sh << 1;
	end
endmodule

// >>> ssfp_pkg.sv
package ssfp_pkg;

	localparam int WORD_W = 16;
	localparam int LEVEL_W = 4;
	localparam logic [3:0] TX_IRQ_LEVEL = 4'h4;
	localparam logic [3:0] MIN_SIZE_M1 = 4'h3;
	localparam int PRESCALE_MIN = 2;
	localparam int PRESCALE_MAX = 254;
	localparam int RATE_DIV_MAX = 256;
	localparam int SLAVE_RATIO_MIN = 12;
	localparam logic [6:0] PRE_CNT_RST = 7'h00;
	localparam logic [7:0] RATE_CNT_RST = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [3:0] BIT_IDX_RST = 4'h0;

	typedef enum logic {
		SSFP_FMT_SPI,
		SSFP_FMT_PULSE
	} ssfp_fmt_t;

	typedef enum logic [2:0] {
		SSFP_IDLE,
		SSFP_PRE,
		SSFP_BITS,
		SSFP_POST,
		SSFP_GAP
	} ssfp_state_t;

	typedef struct packed {
		logic enable;
		logic master;
		ssfp_fmt_t fmt;
		logic cpol;
		logic cpha;
		logic [3:0] size_m1;
		logic [7:0] prescale;
		logic [7:0] rate;
	} ssfp_cfg_t;

	typedef struct packed {
		logic o;
		logic oe;
	} ssfp_pin_t;

endpackage
